// *** cas_seq.sv ***
`default_nettype none
module cas_seq
    import cas_pkg::*;
(
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // operator pins, asynchronous
    input  wire logic [CAS_NKEYS-1:0] key_raw,
    input  wire logic [2:0]           knob_raw,
    input  wire logic                 pad_short_raw,
    // measurement engine, same clock
    input  wire logic                 meas_valid,
    input  wire logic [15:0]          meas_value,
    // nonvolatile store contents, same clock
    input  wire logic [11:0]          nv_counter,
    input  wire logic [15:0]          nv_password,
    // measurement request
    output logic                      meas_req,
    output logic [4:0]                meas_step,
    // nonvolatile write port
    output logic                      nv_wr,
    output logic [5:0]                nv_addr,
    output logic [15:0]               nv_wdata,
    // display and sounder
    output logic                      in_cal,
    output cas_disp_e                 disp_code,
    output logic [15:0]               disp_num,
    output logic                      beep_single,
    output logic                      beep_double
);

    typedef enum logic [3:0] {
        ST_IDLE, ST_BANNER, ST_COUNT, ST_PW_IN, ST_NEW_PW, ST_STEP, ST_MEAS, ST_COMMIT, ST_END
    } cas_state_e;

    logic [CAS_NKEYS-1:0] key_s1_r;
    logic [CAS_NKEYS-1:0] key_s2_r;
    logic [CAS_NKEYS-1:0] key_d_r;
    logic [2:0]           knob_s1_r;
    logic [2:0]           knob_s2_r;
    logic [2:0]           knob_d_r;
    logic                 pad_s1_r;
    logic                 pad_s2_r;
    logic                 pad_d_r;
    logic [CAS_NKEYS-1:0] press;
    logic                 pad_press;

    cas_state_e  state_r,   state_nxt;
    logic [4:0]  step_r,    step_nxt;
    logic [4:0]  cidx_r,    cidx_nxt;
    logic [15:0] pw_buf_r,  pw_buf_nxt;
    logic [2:0]  pw_cnt_r,  pw_cnt_nxt;
    logic        beep1_r,   beep1_nxt;
    logic        beep2_r,   beep2_nxt;
    logic        mreq_r,    mreq_nxt;
    logic        nv_wr_r,   nv_wr_nxt;
    logic [5:0]  nv_addr_r, nv_addr_nxt;
    logic [15:0] nv_wd_r,   nv_wd_nxt;
    cas_disp_e   disp_r,    disp_nxt;
    logic [15:0] dnum_r,    dnum_nxt;
    logic        in_cal_r,  in_cal_nxt;
    logic        cap_en;

    // staged factors, not cleared by reset; a half-run sequence never lands as only the commit burst stores them
    logic [15:0] stage_r [0:CAS_STEPS-1];

    logic [15:0] ref_val;
    logic [15:0] diff;
    logic [15:0] tol;
    logic        in_range;
    logic        any_press;
    logic [3:0]  press_digit;

    // two-flop synchronisers; the edge detectors only look at the second stage
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            key_s1_r  <= '0;
            key_s2_r  <= '0;
            key_d_r   <= '0;
            knob_s1_r <= KNOB_OFF;
            knob_s2_r <= KNOB_OFF;
            knob_d_r  <= KNOB_OFF;
            pad_s1_r  <= 1'b0;
            pad_s2_r  <= 1'b0;
            pad_d_r   <= 1'b0;
        end
        else
        begin
            key_s1_r  <= key_raw;
            key_s2_r  <= key_s1_r;
            key_d_r   <= key_s2_r;
            knob_s1_r <= knob_raw;
            knob_s2_r <= knob_s1_r;
            knob_d_r  <= knob_s2_r;
            pad_s1_r  <= pad_short_raw;
            pad_s2_r  <= pad_s1_r;
            pad_d_r   <= pad_s2_r;
        end
    end

    assign press     = key_s2_r & ~key_d_r;
    assign pad_press = pad_s2_r & ~pad_d_r;
    assign any_press = |press;

    // lowest-numbered pressed button gives the digit
    always_comb
    begin
        press_digit = 4'h0;
        for (int i = CAS_NKEYS - 1; i >= 0; i--)
        begin
            if (press[i])
                press_digit = CAS_KEY_DIGIT[i];
        end
    end

    // acceptance window around the step's reference
    assign ref_val  = CAS_STEP_REF[step_r];
    assign diff     = (meas_value >= ref_val) ? meas_value - ref_val : ref_val - meas_value;
    assign tol      = ((ref_val >> CAS_TOL_SHIFT) > CAS_TOL_MIN) ? (ref_val >> CAS_TOL_SHIFT) : CAS_TOL_MIN;
    assign in_range = (diff <= tol);

    // three-digit bcd increment for the counter
    function automatic logic [11:0] cas_bcd_inc(input logic [11:0] v);
        logic [11:0] r;
        r = v;
        if (r[3:0] != 4'h9)
            r[3:0] = r[3:0] + 4'h1;
        else
        begin
            r[3:0] = 4'h0;
            if (r[7:4] != 4'h9)
                r[7:4] = r[7:4] + 4'h1;
            else
            begin
                r[7:4]  = 4'h0;
                r[11:8] = (r[11:8] == 4'h9) ? 4'h0 : r[11:8] + 4'h1;
            end
        end
        return r;
    endfunction : cas_bcd_inc

    // sequencer next state
    always_comb
    begin
        state_nxt   = state_r;
        step_nxt    = step_r;
        cidx_nxt    = cidx_r;
        pw_buf_nxt  = pw_buf_r;
        pw_cnt_nxt  = pw_cnt_r;
        beep1_nxt   = 1'b0;
        beep2_nxt   = 1'b0;
        mreq_nxt    = 1'b0;
        nv_wr_nxt   = 1'b0;
        nv_addr_nxt = nv_addr_r;
        nv_wd_nxt   = nv_wd_r;
        cap_en      = 1'b0;
        case (state_r)
            ST_IDLE:
            begin
                if (knob_d_r == KNOB_OFF && knob_s2_r == ac_volt_position && key_s2_r[KEY_EXTREMES])
                    state_nxt = ST_BANNER;
            end
            ST_BANNER:
            begin
                if (press[KEY_STORE])
                    state_nxt = ST_COUNT;
            end
            ST_COUNT:
            begin
                if (press[KEY_STORE])
                begin
                    state_nxt  = ST_PW_IN;
                    pw_cnt_nxt = 3'h0;
                    pw_buf_nxt = 16'h0000;
                end
            end
            ST_PW_IN:
            begin
                if (pw_cnt_r != CAS_PW_FULL)
                begin
                    if (any_press)
                    begin
                        pw_buf_nxt = {pw_buf_r[11:0], press_digit};
                        pw_cnt_nxt = pw_cnt_r + 3'h1;
                    end
                end
                else if (press[KEY_STORE] || press[KEY_RANGE])
                begin
                    pw_cnt_nxt = 3'h0;
                    pw_buf_nxt = 16'h0000;
                    if (pw_buf_r != nv_password)
                        beep2_nxt = 1'b1;
                    else if (press[KEY_STORE])
                    begin
                        state_nxt = ST_STEP;
                        step_nxt  = 5'h00;
                    end
                    else
                        state_nxt = ST_NEW_PW;
                end
            end
            ST_NEW_PW:
            begin
                if (pw_cnt_r != CAS_PW_FULL)
                begin
                    if (any_press)
                    begin
                        pw_buf_nxt = {pw_buf_r[11:0], press_digit};
                        pw_cnt_nxt = pw_cnt_r + 3'h1;
                    end
                end
                else if (press[KEY_STORE])
                begin
                    nv_wr_nxt   = 1'b1;
                    nv_addr_nxt = CAS_NV_PW_ADDR;
                    nv_wd_nxt   = pw_buf_r;
                    state_nxt   = ST_BANNER;
                end
            end
            ST_STEP:
            begin
                if (press[KEY_STORE])
                begin
                    if (knob_s2_r != CAS_STEP_KNOB[step_r])
                        beep2_nxt = 1'b1;
                    else
                    begin
                        mreq_nxt  = 1'b1;
                        state_nxt = ST_MEAS;
                    end
                end
            end
            ST_MEAS:
            begin
                // the operator keeps source and knob still until the step moves on
                if (meas_valid)
                begin
                    state_nxt = ST_STEP;
                    if (!in_range)
                        beep2_nxt = 1'b1;
                    else
                    begin
                        cap_en    = 1'b1;
                        beep1_nxt = CAS_LONG_MASK[step_r];
                        if (step_r == CAS_LAST_STEP)
                        begin
                            state_nxt = ST_COMMIT;
                            cidx_nxt  = 5'h00;
                        end
                        else
                            step_nxt = step_r + 5'h01;
                    end
                end
            end
            ST_COMMIT:
            begin
                // one word a cycle: all factors, then the counter
                nv_wr_nxt = 1'b1;
                if (cidx_r == CAS_CNT_SLOT)
                begin
                    nv_addr_nxt = CAS_NV_CNT_ADDR;
                    nv_wd_nxt   = {4'h0, cas_bcd_inc(nv_counter)};
                    state_nxt   = ST_END;
                end
                else
                begin
                    nv_addr_nxt = {1'b0, cidx_r};
                    nv_wd_nxt   = stage_r[cidx_r];
                    cidx_nxt    = cidx_r + 5'h01;
                end
            end
            ST_END:
            begin
                if (press[KEY_STORE])
                    state_nxt = ST_IDLE;
            end
            default:
                state_nxt = ST_IDLE;
        endcase
        // two samples of off abandon the menu except during commit; staged factors never land
        if (state_r != ST_IDLE && state_r != ST_COMMIT && knob_s2_r == KNOB_OFF && knob_d_r == KNOB_OFF)
            state_nxt = ST_IDLE;
        // pad short restores the default; held off in idle, and during commit to keep the burst whole
        if (pad_press && state_r != ST_IDLE && state_r != ST_COMMIT)
        begin
            beep1_nxt   = 1'b1;
            nv_wr_nxt   = 1'b1;
            nv_addr_nxt = CAS_NV_PW_ADDR;
            nv_wd_nxt   = CAS_PW_DEFAULT;
        end
    end

    // display contents follow state and held keys
    always_comb
    begin
        disp_nxt   = DISP_NORMAL;
        dnum_nxt   = 16'h0000;
        in_cal_nxt = (state_nxt != ST_IDLE);
        case (state_nxt)
            ST_IDLE:   disp_nxt = DISP_NORMAL;
            ST_BANNER: disp_nxt = DISP_BANNER;
            ST_COUNT:
            begin
                disp_nxt = DISP_COUNT;
                dnum_nxt = {4'h0, nv_counter};
            end
            ST_PW_IN:  disp_nxt = DISP_QUERY;
            ST_NEW_PW: disp_nxt = DISP_DASH;
            ST_STEP, ST_MEAS, ST_COMMIT:
            begin
                if (key_s2_r[KEY_FUNC1])
                begin
                    disp_nxt = DISP_RAW;
                    dnum_nxt = meas_value;
                end
                else if (key_s2_r[KEY_EXTREMES])
                begin
                    disp_nxt = DISP_AMPL;
                    dnum_nxt = CAS_STEP_REF[step_nxt];
                end
                else if (key_s2_r[KEY_FREQ])
                begin
                    disp_nxt = DISP_FREQ;
                    dnum_nxt = CAS_STEP_FREQ[step_nxt];
                end
                else
                begin
                    disp_nxt = DISP_STEP;
                    dnum_nxt = {11'h000, step_nxt} + 16'h0001;
                end
            end
            ST_END:    disp_nxt = DISP_END;
            default:   disp_nxt = DISP_NORMAL;
        endcase
    end

    // state registers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_r   <= ST_IDLE;
            step_r    <= 5'h00;
            cidx_r    <= 5'h00;
            pw_buf_r  <= 16'h0000;
            pw_cnt_r  <= 3'h0;
            beep1_r   <= 1'b0;
            beep2_r   <= 1'b0;
            mreq_r    <= 1'b0;
            nv_wr_r   <= 1'b0;
            nv_addr_r <= 6'h00;
            nv_wd_r   <= 16'h0000;
            disp_r    <= DISP_NORMAL;
            dnum_r    <= 16'h0000;
            in_cal_r  <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            step_r    <= step_nxt;
            cidx_r    <= cidx_nxt;
            pw_buf_r  <= pw_buf_nxt;
            pw_cnt_r  <= pw_cnt_nxt;
            beep1_r   <= beep1_nxt;
            beep2_r   <= beep2_nxt;
            mreq_r    <= mreq_nxt;
            nv_wr_r   <= nv_wr_nxt;
            nv_addr_r <= nv_addr_nxt;
            nv_wd_r   <= nv_wd_nxt;
            disp_r    <= disp_nxt;
            dnum_r    <= dnum_nxt;
            in_cal_r  <= in_cal_nxt;
        end
    end

    // staging store: offset correction, the real math lives in the front end
    always_ff @(posedge mclk)
    begin
        if (cap_en)
            stage_r[step_r] <= ref_val - meas_value;
    end

    assign meas_req    = mreq_r;
    assign meas_step   = step_r;
    assign nv_wr       = nv_wr_r;
    assign nv_addr     = nv_addr_r;
    assign nv_wdata    = nv_wd_r;
    assign in_cal      = in_cal_r;
    assign disp_code   = disp_r;
    assign disp_num    = dnum_r;
    assign beep_single = beep1_r;
    assign beep_double = beep2_r;

endmodule : cas_seq
`default_nettype wire

// *** cas_pkg.sv ***
`default_nettype none
package cas_pkg;

    // sequence length and table index of the final step
    localparam int         CAS_STEPS     = 31;
    localparam logic [4:0] CAS_LAST_STEP = 5'h1e;
    localparam logic [4:0] CAS_CNT_SLOT  = 5'h1f;   // commit slot that carries the counter

    // pushbutton indices on the key vector
    localparam int CAS_NKEYS     = 6;
    localparam int KEY_STORE     = 0;   // store_advance_key
    localparam int KEY_RANGE     = 1;
    localparam int KEY_EXTREMES  = 2;   // extremes_key
    localparam int KEY_FREQ      = 3;   // frequency_key
    localparam int KEY_FUNC1     = 4;   // first function key, shows raw value
    localparam int KEY_LIGHT     = 5;

    // button to password digit table
    localparam logic [3:0] CAS_KEY_DIGIT [0:CAS_NKEYS-1] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6};

    // rotary knob encoding
    localparam logic [2:0] KNOB_OFF       = 3'h0;
    localparam logic [2:0] ac_volt_position = 3'h1;
    localparam logic [2:0] KNOB_DCV       = 3'h2;
    localparam logic [2:0] KNOB_MV        = 3'h3;
    localparam logic [2:0] KNOB_OHM       = 3'h4;
    localparam logic [2:0] KNOB_DIODE     = 3'h5;
    localparam logic [2:0] KNOB_AMP       = 3'h6;
    localparam logic [2:0] KNOB_UA        = 3'h7;

    // password and nonvolatile map
    localparam int          CAS_PW_DIGITS   = 4;
    localparam logic [2:0]  CAS_PW_FULL     = 3'h4;
    localparam logic [15:0] CAS_PW_DEFAULT  = 16'h1234;
    localparam logic [5:0]  CAS_NV_CNT_ADDR = 6'h1f;
    localparam logic [5:0]  CAS_NV_PW_ADDR  = 6'h20;

    // acceptance window: reference / 8, never narrower than the floor
    localparam int          CAS_TOL_SHIFT = 3;
    localparam logic [15:0] CAS_TOL_MIN   = 16'h0010;

    // per-step function position, reference in display counts, frequency in hz
    localparam logic [2:0] CAS_STEP_KNOB [0:CAS_STEPS-1] = '{
        3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h3, 3'h3,
        3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h5, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6,
        3'h6, 3'h7, 3'h7, 3'h7, 3'h7};
    localparam logic [15:0] CAS_STEP_REF [0:CAS_STEPS-1] = '{
        16'h1770, 16'h1770, 16'h1770, 16'h1770, 16'h1770, 16'h1770, 16'h1770, 16'h1770,
        16'h1770, 16'h1770, 16'h1770, 16'h1770, 16'h1770, 16'h1770, 16'h1770, 16'h1770,
        16'h1770, 16'h1770, 16'h0000, 16'h01f4, 16'h0bb8, 16'h1770, 16'h1770, 16'h1770,
        16'h0fa0, 16'h1770, 16'h0fa0, 16'h1770, 16'h1770, 16'h1770, 16'h1770};
    localparam logic [15:0] CAS_STEP_FREQ [0:CAS_STEPS-1] = '{
        16'h003c, 16'h4e20, 16'h003c, 16'h4e20, 16'h003c, 16'h4e20, 16'h003c, 16'h2710,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h003c, 16'h0000, 16'h003c,
        16'h003c, 16'h0000, 16'h0000, 16'h003c, 16'h003c, 16'h0000, 16'h0000};
    // steps whose processing runs long and end with a completion beep
    localparam logic [30:0] CAS_LONG_MASK = 31'h006a0000;

    // what the display shows
    typedef enum logic [3:0] {
        DISP_NORMAL, DISP_BANNER, DISP_COUNT, DISP_QUERY, DISP_DASH,
        DISP_STEP, DISP_RAW, DISP_AMPL, DISP_FREQ, DISP_END
    } cas_disp_e;

endpackage : cas_pkg
`default_nettype wire

// *** cas_seq_properties.sv ***
`default_nettype none
module cas_seq_chk
    import cas_pkg::*;
(
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst,
    // stored counter
    input wire logic [11:0] nv_counter,
    // measurement and store ports
    input wire logic        meas_req,
    input wire logic [4:0]  meas_step,
    input wire logic        nv_wr,
    input wire logic [5:0]  nv_addr,
    input wire logic [15:0] nv_wdata,
    // display and sounder
    input wire logic        in_cal,
    input var  cas_disp_e   disp_code,
    input wire logic        beep_single,
    input wire logic        beep_double
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // three-digit decimal increment, 999 wraps to 000
    function automatic logic [11:0] bcd_inc(input logic [11:0] c);
        logic [11:0] r;
        r = c + 12'h001;
        if (r[3:0] == 4'ha)
            r = r + 12'h006;
        if (r[7:4] == 4'ha)
            r = r + 12'h060;
        if (r[11:8] == 4'ha)
            r = 12'h000;
        return r;
    endfunction : bcd_inc

    // request pulses and step sequencing
    property p_req_pulse; meas_req |=> !meas_req; endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("request held two cycles");
    property p_step_range; meas_step <= CAS_LAST_STEP; endproperty
    a_step_range: assert property (p_step_range) else $error("step index past last");
    property p_step_adv; $changed(meas_step) |-> meas_step == $past(meas_step) + 5'h01 || meas_step == 5'h00;
    endproperty
    a_step_adv: assert property (p_step_adv) else $error("step skipped");
    property p_dbl_stay; beep_double |=> meas_step == $past(meas_step, 2); endproperty
    a_dbl_stay: assert property (p_dbl_stay) else $error("refused step moved");
    // nonvolatile writes: pad restore, commit burst, counter word
    property p_pad; nv_wr && beep_single && nv_addr == CAS_NV_PW_ADDR |-> nv_wdata == CAS_PW_DEFAULT; endproperty
    a_pad: assert property (p_pad) else $error("pad restore wrong value");
    property p_burst; nv_wr && nv_addr == 6'h00 |-> ##31 (nv_wr && nv_addr == CAS_NV_CNT_ADDR)
        ##[0:2] (disp_code == DISP_END); endproperty
    a_burst: assert property (p_burst) else $error("commit burst broken");
    property p_consec; nv_wr && nv_addr < CAS_NV_CNT_ADDR |=> nv_wr && nv_addr == $past(nv_addr) + 6'h01;
    endproperty
    a_consec: assert property (p_consec) else $error("factor writes not back to back");
    property p_count; nv_wr && nv_addr == CAS_NV_CNT_ADDR |-> nv_wdata == {4'h0, bcd_inc(nv_counter)};
    endproperty
    a_count: assert property (p_count) else $error("counter word wrong");
    // leaving calibration and idle quiet
    property p_exit; $fell(in_cal) |-> disp_code == DISP_NORMAL; endproperty
    a_exit: assert property (p_exit) else $error("exit without normal display");
    property p_idle; !in_cal |-> !nv_wr; endproperty
    a_idle: assert property (p_idle) else $error("store written outside menu");
    c_commit: cover property (nv_wr && nv_addr == CAS_NV_CNT_ADDR);
    c_pad: cover property (nv_wr && beep_single);
    c_refuse: cover property (beep_double && in_cal);
endmodule : cas_seq_chk

bind cas_seq cas_seq_chk cas_seq_chk_i (.mclk(mclk), .rst(rst), .nv_counter(nv_counter), .meas_req(meas_req),
    .meas_step(meas_step), .nv_wr(nv_wr), .nv_addr(nv_addr), .nv_wdata(nv_wdata), .in_cal(in_cal),
    .disp_code(disp_code), .beep_single(beep_single), .beep_double(beep_double));
`default_nettype wire

// *** cas_ref.sv ***
`default_nettype none
module cas_ref
    import cas_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // bench controls: reading offset and answer delay
    input  wire logic [15:0] err,
    input  wire logic [7:0]  lat,
    // measurement link
    input  wire logic        meas_req,
    input  wire logic [4:0]  meas_step,
    output var  logic        meas_valid,
    output wire logic [15:0] meas_value,
    // nonvolatile store
    input  wire logic        nv_wr,
    input  wire logic [5:0]  nv_addr,
    input  wire logic [15:0] nv_wdata,
    output wire logic [11:0] nv_counter,
    output wire logic [15:0] nv_password
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [0:32];
    int          wait_n;
    // words survive rst like power loss; delivered state is counter 001
    initial
    begin
        foreach (mem[a])
            mem[a] = 16'h0000;
        mem[31] = 16'h0001;
        mem[32] = CAS_PW_DEFAULT;
        meas_valid = 1'b0;
        wait_n = 0;
    end
    // source held steady from request to answer, and between groups
    assign meas_value = CAS_STEP_REF[meas_step] + err;
    assign nv_counter = mem[31][11:0];
    assign nv_password = mem[32];
    // reading arrives lat+2 cycles after the request
    always @(posedge mclk)
    begin
        meas_valid <= !rst && wait_n == 1;
        wait_n <= rst ? 0 : meas_req ? int'(lat) + 1 : (wait_n > 0 ? wait_n - 1 : 0);
        if (nv_wr)
            mem[nv_addr] <= nv_wdata;
    end
endmodule : cas_ref
`default_nettype wire

// *** tb_calibration_adjust_sequencer.sv ***
`default_nettype none
module tb_calibration_adjust_sequencer
    import cas_pkg::*;
    ();
    timeunit 1ns;
    timeprecision 1ns;
    // design pins and partner controls
    logic        mclk, rst, pad, meas_req, meas_valid, nv_wr, in_cal, beep_single, beep_double;
    logic [5:0]  key, nv_addr;
    logic [2:0]  knob;
    logic [4:0]  meas_step;
    logic [7:0]  lat;
    logic [11:0] nv_counter;
    logic [15:0] meas_value, nv_wdata, nv_password, disp_num, err, npw;
    logic [15:0] e [0:CAS_STEPS-1];
    cas_disp_e   disp_code;
    int          n_mismatch, checked, n_s, n_d, n_w, s0, d0, w;
    integer      seed;

    cas_seq cas_seq_i (.mclk(mclk), .rst(rst), .key_raw(key), .knob_raw(knob), .pad_short_raw(pad),
        .meas_valid(meas_valid), .meas_value(meas_value), .nv_counter(nv_counter), .nv_password(nv_password),
        .meas_req(meas_req), .meas_step(meas_step), .nv_wr(nv_wr), .nv_addr(nv_addr), .nv_wdata(nv_wdata),
        .in_cal(in_cal), .disp_code(disp_code), .disp_num(disp_num), .beep_single(beep_single),
        .beep_double(beep_double));
    cas_ref cas_ref_i (.mclk(mclk), .rst(rst), .err(err), .lat(lat), .meas_req(meas_req), .meas_step(meas_step),
        .meas_valid(meas_valid), .meas_value(meas_value), .nv_wr(nv_wr), .nv_addr(nv_addr), .nv_wdata(nv_wdata),
        .nv_counter(nv_counter), .nv_password(nv_password));

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // one-cycle pulses are tallied here so no check can miss them
    always @(negedge mclk)
    begin
        n_s <= rst ? 0 : n_s + int'(beep_single === 1'b1);
        n_d <= rst ? 0 : n_d + int'(beep_double === 1'b1);
        n_w <= rst ? 0 : n_w + int'(nv_wr === 1'b1);
    end

    task automatic chk(input logic ok, input string what);
        checked++;
        if (ok !== 1'b1)
        begin
            n_mismatch++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask : chk
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc
    // pins pass a synchroniser, so every change is held six cycles
    task automatic press(input int k);
        key[k] <= 1'b1;
        cyc(6);
        key[k] <= 1'b0;
        cyc(6);
    endtask : press
    task automatic setknob(input logic [2:0] v);
        knob <= v;
        cyc(6);
    endtask : setknob
    task automatic pw(input logic [15:0] v);
        for (int i = 3; i >= 0; i--)
            press(int'(v[4*i +: 4]) - 1);
    endtask : pw
    task automatic enter();
        setknob(KNOB_OFF);
        key[KEY_EXTREMES] <= 1'b1;
        cyc(4);
        setknob(ac_volt_position);
        key[KEY_EXTREMES] <= 1'b0;
        cyc(6);
    endtask : enter
    function automatic int tol(input logic [15:0] r);
        return (r >> CAS_TOL_SHIFT) < CAS_TOL_MIN ? int'(CAS_TOL_MIN) : int'(r >> CAS_TOL_SHIFT);
    endfunction : tol

    // watchdog, far beyond the expected few thousand cycles
    initial
    begin
        cyc(20000);
        n_mismatch++;
        conclude();
    end

    initial
    begin
        seed = 32'h10442ac4;
        rst = 1'b1;
        key = 6'h00;
        knob = KNOB_OFF;
        pad = 1'b0;
        err = 16'h0000;
        lat = 8'h02;
        cyc(12);
        rst <= 1'b0;
        cyc(2);
        chk(in_cal === 1'b0 && disp_code === DISP_NORMAL, "reset state");
        setknob(ac_volt_position);
        chk(in_cal === 1'b0, "entry without key");
        enter();
        chk(in_cal === 1'b1 && disp_code === DISP_BANNER, "banner");
        press(KEY_STORE);
        chk(disp_code === DISP_COUNT && disp_num === 16'h0001, "counter shown");
        press(KEY_STORE);
        chk(disp_code === DISP_QUERY, "query");
        pw(16'h2143);
        press(KEY_RANGE);
        chk(n_d === 1 && disp_code === DISP_QUERY, "old pw refused");
        pw(CAS_PW_DEFAULT);
        press(KEY_RANGE);
        chk(disp_code === DISP_DASH, "dashes");
        for (int i = 0; i < 4; i++)
            npw = {npw[11:0], 4'(1 + $unsigned($random(seed)) % 6)};
        pw(npw);
        press(KEY_STORE);
        chk(nv_password === npw && disp_code === DISP_BANNER, "new pw");
        pad <= 1'b1;
        cyc(6);
        pad <= 1'b0;
        cyc(6);
        chk(nv_password === CAS_PW_DEFAULT && n_s === 1, "pad restore");
        press(KEY_STORE);
        press(KEY_STORE);
        pw(16'h1243);
        press(KEY_STORE);
        chk(n_d === 2 && disp_code === DISP_QUERY, "pw refused");
        pw(CAS_PW_DEFAULT);
        press(KEY_STORE);
        chk(disp_code === DISP_STEP && disp_num === 16'h0001, "first step");
        // held keys on the first step
        err <= 16'h0005;
        key <= 6'h10;
        cyc(6);
        chk(disp_code === DISP_RAW && disp_num === CAS_STEP_REF[0] + 16'h0005, "raw");
        key <= 6'h04;
        cyc(6);
        chk(disp_code === DISP_AMPL && disp_num === CAS_STEP_REF[0], "amplitude");
        key <= 6'h08;
        cyc(6);
        chk(disp_code === DISP_FREQ && disp_num === CAS_STEP_FREQ[0], "frequency");
        key <= 6'h00;
        cyc(6);
        // wrong knob, then a reading one count past the window
        setknob(KNOB_DCV);
        press(KEY_STORE);
        chk(n_d === 3 && disp_num === 16'h0001, "wrong knob");
        setknob(ac_volt_position);
        err <= 16'(tol(CAS_STEP_REF[0]) + 1);
        press(KEY_STORE);
        chk(n_d === 4 && disp_num === 16'h0001, "out of range");
        err <= 16'h0000;
        press(KEY_STORE);
        setknob(KNOB_OFF);
        chk(in_cal === 1'b0 && n_w === 2 && cas_ref_i.mem[0] === 16'h0000, "abort keeps store");
        // full sequence with random in-window readings and delays
        enter();
        press(KEY_STORE);
        press(KEY_STORE);
        pw(CAS_PW_DEFAULT);
        press(KEY_STORE);
        d0 = n_d;
        for (int i = 0; i < CAS_STEPS; i++)
        begin
            setknob(CAS_STEP_KNOB[i]);
            e[i] = 16'($unsigned($random(seed)) % (tol(CAS_STEP_REF[i]) + 1));
            if (i == 5)
                e[i] = 16'(tol(CAS_STEP_REF[i]));
            err <= e[i];
            lat <= CAS_LONG_MASK[i] ? 8'hc8 : 8'($unsigned($random(seed)) % 16);
            s0 = n_s;
            press(KEY_STORE);
            for (w = 0; w < 400 && !((i < 30) ? disp_num === 16'(i + 2) : disp_code === DISP_END); w++)
                cyc(1);
            chk(w < 400, "step advance");
            chk(n_s - s0 === int'(CAS_LONG_MASK[i]), "long step beep");
        end
        chk(n_d === d0, "in-window readings accepted");
        for (int i = 0; i < CAS_STEPS; i++)
            chk(cas_ref_i.mem[i] === 16'h0000 - e[i], "factor");
        press(KEY_STORE);
        chk(cas_ref_i.mem[31] === 16'h0002 && n_w === 34, "counter and burst");
        chk(in_cal === 1'b0 && disp_code === DISP_NORMAL, "back to meter");
        conclude();
    end
endmodule : tb_calibration_adjust_sequencer
`default_nettype wire
